// ### common/cacfg_map.svh
`ifndef CACFG_MAP_SVH
`define CACFG_MAP_SVH

// field positions of the auxiliary configuration word
`define CACFG_BIT_EARLY_RESP      30
`define CACFG_BIT_IPREFETCH       29
`define CACFG_BIT_DPREFETCH       28
`define CACFG_BIT_NONSEC_INTR     27
`define CACFG_BIT_NONSEC_LOCKDOWN 26
`define CACFG_BIT_ROUND_ROBIN     25
`define CACFG_ALLOC_HI            24
`define CACFG_ALLOC_LO            23
`define CACFG_BIT_SHARED_IGNORE   22
`define CACFG_BIT_PARITY          21
`define CACFG_BIT_EVENT_BUS       20
`define CACFG_WAY_SIZE_HI         19
`define CACFG_WAY_SIZE_LO         17
`define CACFG_BIT_ASSOC16         16
`define CACFG_BIT_SHARED_INV      13
`define CACFG_BIT_EXCLUSIVE       12
`define CACFG_BIT_SB_DEV_LIMIT    11
`define CACFG_BIT_SO_DEV_PRIO     10
`define CACFG_BIT_FULL_LINE_ZERO  0

// writable bits: 31, 15:14 and 9:1 are reserved
`define CACFG_WRITE_MASK          32'h7FFF_3C01

// reset value apart from the strapped way size and associativity
`define CACFG_RESET_VALUE         32'h0200_0000

// write-allocate field codes
`define CACFG_ALLOC_USE_BUS       2'h0
`define CACFG_ALLOC_FORCE_NONE    2'h1
`define CACFG_ALLOC_FORCE_ON      2'h2

// way-size codes at both ends of the legal range
`define CACFG_WAY_SIZE_MIN        3'h1
`define CACFG_WAY_SIZE_MAX        3'h6

// victim selection
`define CACFG_LFSR_SEED           16'hACE1
`define CACFG_LFSR_TAPS           16'hB400
`define CACFG_WAYS_8_MASK         4'h7
`define CACFG_WAYS_16_MASK        4'hF

// store buffer depth seen by the device-write limit
`define CACFG_SB_SLOTS            4'h8

`endif

// ### common/cacfg_pkg.sv
package cacfg_pkg;

  // write response codes as carried on the bus
  typedef enum logic [1:0] {
    CACFG_RESP_OKAY   = 2'h0,
    CACFG_RESP_SLVERR = 2'h2,
    CACFG_RESP_DECERR = 2'h3
  } cacfg_resp_t;

  // which requester wins the master-port slot
  typedef enum logic [1:0] {
    CACFG_GRANT_NONE,
    CACFG_GRANT_SO_DEV,
    CACFG_GRANT_CACHEABLE
  } cacfg_grant_t;

endpackage : cacfg_pkg

// ### logic/cacfg_decode.sv
`include "cacfg_map.svh"

// turns the stored word into the effective controls the datapath uses
module cacfg_decode (
  // stored configuration word
  input  wire logic [31:0] cfg_word,
  // bus cache allocate attribute of the current write
  input  wire logic        bus_alloc_attr,
  // effective controls
  output logic             write_allocate_hint,
  output logic [2:0]       way_size_eff,
  output logic [3:0]       way_index_mask,
  output logic             shared_ignore,
  output logic             shared_invalidate_eff
);
  import cacfg_pkg::*;

  wire logic [1:0] alloc_field = cfg_word[`CACFG_ALLOC_HI:`CACFG_ALLOC_LO];
  wire logic [2:0] way_field   = cfg_word[`CACFG_WAY_SIZE_HI:`CACFG_WAY_SIZE_LO];
  wire logic       assoc16     = cfg_word[`CACFG_BIT_ASSOC16];

  // code 11 falls through to the bus attribute like code 00
  assign write_allocate_hint = (alloc_field == `CACFG_ALLOC_FORCE_NONE) ? 1'b0 :
                               (alloc_field == `CACFG_ALLOC_FORCE_ON)   ? 1'b1 :
                               bus_alloc_attr;

  // reserved codes fold onto the nearest legal size
  assign way_size_eff = (way_field < `CACFG_WAY_SIZE_MIN) ? `CACFG_WAY_SIZE_MIN :
                        (way_field > `CACFG_WAY_SIZE_MAX) ? `CACFG_WAY_SIZE_MAX :
                        way_field;

  // 8 ways need three index bits, 16 ways four
  assign way_index_mask = assoc16 ? `CACFG_WAYS_16_MASK : `CACFG_WAYS_8_MASK;

  // override wins: shared invalidate only acts while sharing is honoured
  assign shared_ignore         = cfg_word[`CACFG_BIT_SHARED_IGNORE];
  assign shared_invalidate_eff = cfg_word[`CACFG_BIT_SHARED_INV] &&
                                 !cfg_word[`CACFG_BIT_SHARED_IGNORE];

endmodule // cacfg_decode

// ### logic/cacfg_top.sv
// Notes on behaviour
// - bit 30 enables early write responses; resets to zero.
// - bit 29 enables instruction prefetch; resets to zero.
// - bit 28 enables data prefetch; resets to zero.
// - bit 27 lets non-secure accesses reach interrupt clear and mask registers.
// - bit 26 lets non-secure writes modify lockdown registers; reset blocks them.
// - bit 25 picks round-robin (reset) or LFSR pseudo-random victim ways.
// - bits 24:23 pass, force off, or force on the write-allocate hint; 11 passes.
// - bit 22 makes incoming shareable attributes be ignored.
// - bit 21 enables parity, bit 20 the event monitor bus; both reset off.
// - bits 19:17 way size 16KB..512KB, reserved codes clamp; bit 16 8/16 ways.
// - bit 13 enables shared invalidate only while bit 22 is clear.
// - bit 12 enables exclusive cache operation; resets off.
// - bit 11 keeps one store buffer slot free of device writes.
// - bit 10 gives strongly ordered and device reads top arbitration priority.
// - bit 0 enables full-line-of-zero writes; resets off.
// - non-secure write gets DECERR, write while cache on SLVERR; DECERR first.
// - way size and associativity reset from external strap inputs.
`include "cacfg_map.svh"

module cacfg_top (
  // clock and synchronous reset
  input  wire logic                 clk,
  input  wire logic                 reset,
  // straps sampled while reset is high
  input  wire logic [2:0]           way_size_strap,
  input  wire logic                 assoc_strap,
  // main control register state: cache enable bit
  input  wire logic                 cache_enabled,
  // register write port
  input  wire logic                 cfg_wr_valid,
  input  wire logic [31:0]          cfg_wr_data,
  input  wire logic                 cfg_wr_non_secure,
  output logic                      cfg_wr_resp_valid,
  output cacfg_pkg::cacfg_resp_t    cfg_wr_resp,
  // register read port
  input  wire logic                 cfg_rd_valid,
  output logic                      cfg_rd_resp_valid,
  output logic [31:0]               cfg_rd_data,
  // access checks for interrupt and lockdown registers
  input  wire logic                 non_secure_access,
  output logic                      intr_access_allowed,
  output logic                      lockdown_write_allowed,
  // write-allocate and shareable handling of the current access
  input  wire logic                 bus_alloc_attr,
  input  wire logic                 acc_shareable,
  output logic                      write_allocate_hint,
  output logic                      shareable_eff,
  output logic                      shared_invalidate_eff,
  // store buffer admission
  input  wire logic                 sb_req_valid,
  input  wire logic                 sb_req_device,
  input  wire logic [3:0]           sb_used_slots,
  output logic                      sb_accept,
  // master-port arbitration
  input  wire logic                 arb_so_dev_read_req,
  input  wire logic                 arb_cacheable_req,
  output cacfg_pkg::cacfg_grant_t   arb_grant,
  // victim way selection
  input  wire logic                 victim_advance,
  output logic [3:0]                victim_way,
  // plain feature enables
  output logic                      early_resp_en,
  output logic                      iprefetch_en,
  output logic                      dprefetch_en,
  output logic                      parity_en,
  output logic                      event_bus_en,
  output logic                      exclusive_en,
  output logic                      full_line_zero_en,
  output logic                      round_robin_en,
  output logic [2:0]                way_size_eff,
  output logic                      assoc16_en
);
  import cacfg_pkg::*;

  // stored configuration and response state
  logic [31:0]  cfg_reg;
  logic [31:0]  cfg_next;
  logic         wr_resp_valid_reg;
  cacfg_resp_t  wr_resp_reg;
  cacfg_resp_t  wr_resp_next;
  logic         rd_resp_valid_reg;
  logic [31:0]  rd_data_reg;
  logic [15:0]  lfsr_reg;
  logic [15:0]  lfsr_next;
  logic [3:0]   rr_reg;
  logic [3:0]   rr_next;

  // decoded helpers
  wire logic [3:0] way_index_mask;
  wire logic       shared_ignore;
  wire logic       wr_commit;
  wire logic [31:0] strap_word;
  wire logic [31:0] merged_word;

  // secure-only gate, shared by the interrupt and lockdown checks
  function automatic logic gate_ok(input logic nonsec, input logic nonsec_enable);
    gate_ok = !nonsec || nonsec_enable;
  endfunction

  // strapped fields placed at their positions inside an otherwise empty word
  assign strap_word = {12'h000, way_size_strap, assoc_strap, 16'h0000};

  // -------------------------------------------------------------------------
  // write response: non-secure refusal ranks above the cache-enabled refusal
  // -------------------------------------------------------------------------
  assign wr_resp_next = cfg_wr_non_secure ? CACFG_RESP_DECERR :
                        cache_enabled     ? CACFG_RESP_SLVERR :
                        CACFG_RESP_OKAY;

  // only a clean secure write with the cache off reaches the register
  assign wr_commit = cfg_wr_valid && (wr_resp_next == CACFG_RESP_OKAY);

  // reserved bits are dropped on the way in, so they can never read back set
  assign merged_word = cfg_wr_data & `CACFG_WRITE_MASK;

  assign cfg_next = wr_commit ? merged_word : cfg_reg;

  // configuration word; straps replace fixed reset constants for size and ways
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_reg <= `CACFG_RESET_VALUE | strap_word;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // write answers one cycle after the request, refused writes included
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_resp_valid_reg <= 1'b0;
      wr_resp_reg       <= CACFG_RESP_OKAY;
    end else begin
      wr_resp_valid_reg <= cfg_wr_valid;
      wr_resp_reg       <= cfg_wr_valid ? wr_resp_next : CACFG_RESP_OKAY;
    end
  end

  // reads are open to both worlds and return the masked word
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_resp_valid_reg <= 1'b0;
      rd_data_reg       <= 32'h0000_0000;
    end else begin
      rd_resp_valid_reg <= cfg_rd_valid;
      rd_data_reg       <= cfg_rd_valid ? (cfg_reg & `CACFG_WRITE_MASK) : 32'h0000_0000;
    end
  end

  assign cfg_wr_resp_valid = wr_resp_valid_reg;
  assign cfg_wr_resp       = wr_resp_reg;
  assign cfg_rd_resp_valid = rd_resp_valid_reg;
  assign cfg_rd_data       = rd_data_reg;

  // -------------------------------------------------------------------------
  // plain enables straight from the stored word
  // -------------------------------------------------------------------------
  assign early_resp_en     = cfg_reg[`CACFG_BIT_EARLY_RESP];
  assign iprefetch_en      = cfg_reg[`CACFG_BIT_IPREFETCH];
  assign dprefetch_en      = cfg_reg[`CACFG_BIT_DPREFETCH];
  assign parity_en         = cfg_reg[`CACFG_BIT_PARITY];
  assign event_bus_en      = cfg_reg[`CACFG_BIT_EVENT_BUS];
  assign exclusive_en      = cfg_reg[`CACFG_BIT_EXCLUSIVE];
  assign full_line_zero_en = cfg_reg[`CACFG_BIT_FULL_LINE_ZERO];
  assign round_robin_en    = cfg_reg[`CACFG_BIT_ROUND_ROBIN];
  assign assoc16_en        = cfg_reg[`CACFG_BIT_ASSOC16];

  // -------------------------------------------------------------------------
  // security gates for neighbouring registers
  // -------------------------------------------------------------------------
  // interrupt clear and mask: reads and writes alike are gated
  assign intr_access_allowed    = gate_ok(non_secure_access,
                                          cfg_reg[`CACFG_BIT_NONSEC_INTR]);
  // lockdown: only writes are checked here, reads stay open
  assign lockdown_write_allowed = gate_ok(non_secure_access,
                                          cfg_reg[`CACFG_BIT_NONSEC_LOCKDOWN]);

  // -------------------------------------------------------------------------
  // field decode: allocate hint, way size, shareable treatment
  // -------------------------------------------------------------------------
  cacfg_decode u_decode (
    .cfg_word              (cfg_reg),
    .bus_alloc_attr        (bus_alloc_attr),
    .write_allocate_hint   (write_allocate_hint),
    .way_size_eff          (way_size_eff),
    .way_index_mask        (way_index_mask),
    .shared_ignore         (shared_ignore),
    .shared_invalidate_eff (shared_invalidate_eff)
  );

  // with the override on every access is handled as non-shared
  assign shareable_eff = acc_shareable && !shared_ignore;

  // -------------------------------------------------------------------------
  // store buffer admission
  // -------------------------------------------------------------------------
  wire logic sb_has_free     = (sb_used_slots < `CACFG_SB_SLOTS);
  // a device write may not take the last slot; keeps normal writes flowing
  wire logic sb_dev_has_room = (sb_used_slots < (`CACFG_SB_SLOTS - 4'h1));
  wire logic sb_dev_ok       = cfg_reg[`CACFG_BIT_SB_DEV_LIMIT] ? sb_dev_has_room
                                                                : sb_has_free;

  assign sb_accept = sb_req_valid && (sb_req_device ? sb_dev_ok : sb_has_free);

  // -------------------------------------------------------------------------
  // master-port arbitration between the two request classes
  // -------------------------------------------------------------------------
  wire logic so_dev_first = cfg_reg[`CACFG_BIT_SO_DEV_PRIO];

  assign arb_grant = (arb_so_dev_read_req && (so_dev_first || !arb_cacheable_req))
                     ? CACFG_GRANT_SO_DEV
                     : arb_cacheable_req ? CACFG_GRANT_CACHEABLE
                     : CACFG_GRANT_NONE;

  // -------------------------------------------------------------------------
  // victim way selection
  // -------------------------------------------------------------------------
  // galois lfsr keeps running every advance so the random mode never stalls
  assign lfsr_next = lfsr_reg[0] ? ((lfsr_reg >> 1) ^ `CACFG_LFSR_TAPS) : (lfsr_reg >> 1);

  // round-robin wraps at the way count in force
  assign rr_next = ((rr_reg & way_index_mask) == way_index_mask) ? 4'h0
                   : ((rr_reg + 4'h1) & way_index_mask);

  // lfsr state
  always_ff @(posedge clk) begin
    if (reset) begin
      lfsr_reg <= `CACFG_LFSR_SEED;
    end else if (victim_advance) begin
      lfsr_reg <= lfsr_next;
    end
  end

  // round-robin pointer; holds still while the random mode is in use
  always_ff @(posedge clk) begin
    if (reset) begin
      rr_reg <= 4'h0;
    end else if (victim_advance && round_robin_en) begin
      rr_reg <= rr_next;
    end
  end

  // only the low index bits matter, so an 8-way cache never names way 8..15
  assign victim_way = round_robin_en ? (rr_reg & way_index_mask)
                                     : (lfsr_reg[3:0] & way_index_mask);

endmodule // cacfg_top

// ### verif/cacfg_master.sv
// bus master side: one-cycle request pulses, answer taken one edge later
module cacfg_master
  import cacfg_pkg::*;
(
  input  wire logic        clk, cfg_wr_resp_valid, cfg_rd_resp_valid,
  input  wire cacfg_pkg::cacfg_resp_t cfg_wr_resp,
  input  wire logic [31:0] cfg_rd_data,
  output logic             cfg_wr_valid, cfg_wr_non_secure, cfg_rd_valid,
  output logic [31:0]      cfg_wr_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cfg_wr_valid = 1'b0;
    cfg_rd_valid = 1'b0;
    cfg_wr_data = 32'h5a5a_5a5a;
    cfg_wr_non_secure = 1'b0;
  end
  // released lines show inverted data so stale values cannot pass
  task automatic write(input logic [31:0] d, input logic nonsec, output cacfg_resp_t r,
                       output logic ok);
    @(posedge clk);
    #1 cfg_wr_valid = 1'b1;
    cfg_wr_data = d;
    cfg_wr_non_secure = nonsec;
    @(posedge clk);
    #1 cfg_wr_valid = 1'b0;
    cfg_wr_data = ~d;
    cfg_wr_non_secure = ~nonsec;
    ok = cfg_wr_resp_valid;
    r = cfg_wr_resp;
  endtask
  task automatic read(output logic [31:0] d, output logic ok);
    @(posedge clk);
    #1 cfg_rd_valid = 1'b1;
    @(posedge clk);
    #1 cfg_rd_valid = 1'b0;
    ok = cfg_rd_resp_valid;
    d = cfg_rd_data;
  endtask
endmodule // cacfg_master

// ### verif/cacfg_top_assertions.sv
module cacfg_chk
  import cacfg_pkg::*;
(
  // clock, reset and straps
  input wire logic        clk, reset, assoc_strap, cache_enabled,
  input wire logic [2:0]  way_size_strap, way_size_eff,
  // register ports
  input wire logic        cfg_wr_valid, cfg_wr_non_secure, cfg_rd_valid,
  input wire logic        cfg_wr_resp_valid, cfg_rd_resp_valid, early_resp_en,
  input wire logic [31:0] cfg_wr_data, cfg_rd_data,
  input wire cacfg_pkg::cacfg_resp_t  cfg_wr_resp,
  // datapath controls
  input wire logic        non_secure_access, intr_access_allowed, bus_alloc_attr,
  input wire logic        write_allocate_hint, acc_shareable, shareable_eff,
  input wire logic        sb_req_valid, sb_req_device, sb_accept,
  input wire logic        arb_so_dev_read_req, arb_cacheable_req,
  input wire logic [3:0]  sb_used_slots,
  input wire cacfg_pkg::cacfg_grant_t arb_grant
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] shadow_reg;
  wire  [2:0]  ws_raw = shadow_reg[19:17];
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // mirror of the stored word, rebuilt from the write port only
  always_ff @(posedge clk) begin
    if (reset) shadow_reg <= 32'h0200_0000 | {way_size_strap, assoc_strap, 16'h0000};
    else if (cfg_wr_valid && !cfg_wr_non_secure && !cache_enabled)
      shadow_reg <= cfg_wr_data & 32'h7fff_3c01;
  end
  sequence s_wr_ok;
    cfg_wr_valid && !cfg_wr_non_secure && !cache_enabled;
  endsequence
  sequence s_resp(cacfg_resp_t code);
    ##1 cfg_wr_resp_valid && cfg_wr_resp == code;
  endsequence
  AST_WR_OKAY: assert property (s_wr_ok |-> s_resp(CACFG_RESP_OKAY)
    ##0 early_resp_en == $past(cfg_wr_data[30])) else $error("committed write not applied");
  AST_WR_DECERR: assert property (cfg_wr_valid && cfg_wr_non_secure |->
    s_resp(CACFG_RESP_DECERR) ##0 $stable(early_resp_en)) else $error("bad non-secure answer");
  AST_WR_SLVERR: assert property (cfg_wr_valid && !cfg_wr_non_secure && cache_enabled |->
    s_resp(CACFG_RESP_SLVERR) ##0 $stable(early_resp_en)) else $error("bad cache-on answer");
  AST_RD_DATA: assert property (cfg_rd_valid |=>
    cfg_rd_resp_valid && cfg_rd_data == $past(shadow_reg)) else $error("read data wrong");
  AST_INTR_GATE: assert property (
    intr_access_allowed == (!non_secure_access || shadow_reg[27])) else $error("intr gate");
  AST_ALLOC_HINT: assert property (write_allocate_hint ==
    (shadow_reg[24:23] == 2'h2 || (shadow_reg[24:23] != 2'h1 && bus_alloc_attr)))
    else $error("allocate hint wrong");
  AST_SHARE: assert property (
    shareable_eff == (acc_shareable && !shadow_reg[22])) else $error("shareable wrong");
  AST_SB_LIMIT: assert property (sb_req_valid && sb_req_device && shadow_reg[11]
    && sb_used_slots >= 4'h7 |-> !sb_accept) else $error("device took last slot");
  AST_ARB_PRIO: assert property (arb_so_dev_read_req && arb_cacheable_req |->
    arb_grant == (shadow_reg[10] ? CACFG_GRANT_SO_DEV : CACFG_GRANT_CACHEABLE))
    else $error("arbitration wrong");
  AST_WAY_SIZE_STRAP: assert property (way_size_eff == (ws_raw == 3'h0 ? 3'h1 :
    ws_raw == 3'h7 ? 3'h6 : ws_raw)) else $error("way size clamp wrong");
endmodule // cacfg_chk

bind cacfg_top cacfg_chk u_chk (.*);

// ### verif/cache_auxiliary_config_tb.sv
module cache_auxiliary_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import cacfg_pkg::*;
  logic clk, reset, assoc_strap, cache_enabled, cfg_wr_valid, cfg_wr_non_secure, ok, nonsec;
  logic cfg_rd_valid, non_secure_access, bus_alloc_attr, acc_shareable, sb_req_valid;
  logic sb_req_device, arb_so_dev_read_req, arb_cacheable_req, victim_advance;
  logic cfg_wr_resp_valid, cfg_rd_resp_valid, intr_access_allowed, lockdown_write_allowed;
  logic write_allocate_hint, shareable_eff, shared_invalidate_eff, sb_accept;
  logic early_resp_en, iprefetch_en, dprefetch_en, parity_en, event_bus_en;
  logic exclusive_en, full_line_zero_en, round_robin_en, assoc16_en;
  logic [2:0]   way_size_strap, way_size_eff, ws;
  logic [3:0]   sb_used_slots, victim_way, vexp;
  logic [31:0]  cfg_wr_data, cfg_rd_data, d;
  logic [15:0]  lf;
  cacfg_resp_t  cfg_wr_resp, r, er;
  cacfg_grant_t arb_grant, eg;
  int           seed, n_errors, n_compared, i, m;

  cacfg_top    u_dut (.*);
  cacfg_master u_m (.*);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic rd_chk();
    logic [31:0] rd;
    u_m.read(rd, ok);
    chk({ok, rd}, {1'b1, m[31:0]});
  endtask
  // random attributes, then every combinational control against the model word
  task automatic outs_chk();
    {non_secure_access, bus_alloc_attr, acc_shareable, sb_req_valid, sb_req_device,
      arb_so_dev_read_req, arb_cacheable_req} = 7'($random(seed));
    sb_used_slots = 4'($unsigned($random(seed)) % 9);
    #1;
    ws = m[19:17] == 3'h0 ? 3'h1 : m[19:17] == 3'h7 ? 3'h6 : m[19:17];
    eg = (arb_so_dev_read_req && (!arb_cacheable_req || m[10])) ? CACFG_GRANT_SO_DEV :
         arb_cacheable_req ? CACFG_GRANT_CACHEABLE : CACFG_GRANT_NONE;
    chk({early_resp_en, iprefetch_en, dprefetch_en, parity_en, event_bus_en, exclusive_en,
      full_line_zero_en, round_robin_en, assoc16_en, way_size_eff}, {m[30], m[29], m[28],
      m[21], m[20], m[12], m[0], m[25], m[16], ws});
    chk({intr_access_allowed, lockdown_write_allowed}, {!non_secure_access || m[27],
      !non_secure_access || m[26]});
    chk({write_allocate_hint, shareable_eff, shared_invalidate_eff}, {m[24:23] == 2 ||
      (m[24:23] != 1 && bus_alloc_attr), acc_shareable && !m[22], m[13] && !m[22]});
    chk({sb_accept, arb_grant}, {sb_req_valid && sb_used_slots <
      ((sb_req_device && m[11]) ? 4'h7 : 4'h8), eg});
  endtask

  initial begin
    seed = 32'h7f73_def1;
    n_errors = 0;
    n_compared = 0;
    reset = 1'b1;
    victim_advance = 1'b0;
    cache_enabled = 1'b0;
    {way_size_strap, assoc_strap} = 4'($random(seed));
    m = 32'h0200_0000 | {way_size_strap, assoc_strap, 16'h0000};
    // reset values are checked while reset is still held, once the register has loaded
    repeat (5) @(posedge clk);
    #1 outs_chk();
    @(posedge clk);
    #1 reset = 1'b0;
    rd_chk();
    // first sixteen walk every allocate and way-size code, then random accepted and refused writes
    for (i = 0; i < 80; i++) begin
      d = $random(seed);
      {nonsec, cache_enabled} = 2'($random(seed));
      if (i < 16) begin
        {nonsec, cache_enabled} = 2'b00;
        d[24:23] = i[1:0];
        d[19:17] = i[3:1];
      end
      u_m.write(d, nonsec, r, ok);
      er = nonsec ? CACFG_RESP_DECERR : cache_enabled ? CACFG_RESP_SLVERR : CACFG_RESP_OKAY;
      if (!nonsec && !cache_enabled) m = d & 32'h7fff_3c01;
      chk({ok, r}, {1'b1, er});
      outs_chk();
      rd_chk();
    end
    // round robin over 8 then 16 ways, then pseudo-random confined to 8 ways
    cache_enabled = 1'b0;
    vexp = 4'h0;
    lf = 16'hace1;
    for (i = 0; i < 60; i++) begin
      if (i % 20 == 0) begin
        u_m.write(i == 0 ? 32'h0200_0000 : i == 20 ? 32'h0201_0000 : 32'h0, 1'b0, r, ok);
        chk({ok, r}, {1'b1, CACFG_RESP_OKAY});
      end
      @(posedge clk);
      #1 victim_advance = 1'b1;
      @(posedge clk);
      #1 victim_advance = 1'b0;
      // the shift register steps on every advance, whichever policy is in force
      lf = lf[0] ? ((lf >> 1) ^ 16'hb400) : (lf >> 1);
      if (i < 40) vexp = (vexp + 4'h1) & (i < 20 ? 4'h7 : 4'hf);
      chk(victim_way, i < 40 ? vexp : (lf[3:0] & 4'h7));
    end
    give_verdict();
  end
  // watchdog well beyond the expected run of under a thousand cycles
  initial begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule // cache_auxiliary_config_tb
